// file: efc_mac.sv
// Frame transmitter, receive address and type checks, counters and APB registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module efc_mac (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// MII
	input wire logic miiTxClk,
	input wire logic miiRxClk,
	input wire logic miiRxDv,
	input wire logic [3:0] miiRxD,
	input wire logic miiCol,
	output efc_pkg::efc_miitx_t miiTx,
	// Transmit byte stream
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txLast,
	output logic txAck,
	output logic txRewind,
	// Receive report
	output logic rxDone,
	output efc_pkg::efc_rxstat_t rxStatus
);
	import efc_pkg::*;

	typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DATA, TX_PAD, TX_CRC, TX_END, TX_BACKOFF}
		efc_txstate_t;
	typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA, RX_DROP} efc_rxstate_t;

	logic macEnable, txEnable, pauseReq, lockLo, lockHi;
	logic [47:0] stationAddr;
	logic [15:0] pauseTime;
	logic [2:0] viewIndex;
	logic [10:0] viewValue;
	logic [7:0] syncA, syncB;
	logic [1:0] clkPrev;
	logic txEdge, rxEdge, rxDvS, colS;
	logic [3:0] rxDS;
	efc_txstate_t txState;
	efc_rxstate_t rxState;
	logic nibHi, pauseMode, txActive, txStart;
	logic [3:0] hiNib, retryCount, expo;
	logic [10:0] txCnt, txBytes;
	logic [31:0] crc;
	logic [7:0] txByteSel, slotNib;
	logic [9:0] lfsr, backoff_slot_count, backoffTarget, backoffMask;
	logic [143:0] pauseHdr;
	logic rxNibHi, addrHit, mcast, bcast;
	logic [3:0] rxLo;
	logic [7:0] rxByte;
	logic [47:0] addrShift;
	logic [10:0] rxCnt, dataLen, expectLen;
	logic [15:0] typeLen;
	efc_rxstat_t next_rxStat;
	logic setup, accept, wrAccept, mapped;
	logic [31:0] readMux;

	function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Link input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		syncA <= {miiTxClk, miiRxClk, miiRxDv, miiCol, miiRxD};
		syncB <= syncA;
		clkPrev <= syncB[7:6];
	end
	// Edges found a few cycles late; data is held long after the link edge
	assign txEdge = syncB[7] & ~clkPrev[1];
	assign rxEdge = syncB[6] & ~clkPrev[0];
	assign rxDvS = syncB[5];
	assign colS = syncB[4];
	assign rxDS = syncB[3:0];

	// ----------------------------------------------------------------
	// APB slave: one wait state, registered answer
	// ----------------------------------------------------------------
	assign setup = psel & penable & ~pready;
	assign accept = psel & penable & pready;
	assign wrAccept = accept & pwrite & mapped;
	assign mapped = paddr inside {OFF_CTRL, OFF_STATUS, OFF_ADDR_LO, OFF_ADDR_HI, OFF_VIEW,
		OFF_PAUSE};

	always_comb
	begin
		case (paddr)
			OFF_CTRL: readMux = {29'h0, pauseReq, txEnable, macEnable};
			OFF_STATUS: readMux = {14'h0, rxStatus};
			OFF_ADDR_LO: readMux = stationAddr[31:0];
			OFF_ADDR_HI: readMux = {16'h0, stationAddr[47:32]};
			OFF_VIEW: readMux = {16'h0, viewIndex, 2'h0, viewValue};
			OFF_PAUSE: readMux = {16'h0, pauseTime};
			default: readMux = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			prdata <= setup && !pwrite ? readMux : 32'h0;
			pslverr <= setup & ~mapped;
		end
	end

	// Control and pause request; a new request beats the take-up
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			macEnable <= 1'b0;
			txEnable <= 1'b0;
			pauseReq <= 1'b0;
			pauseTime <= PAUSE_TIME_RESET;
			viewIndex <= 3'h0;
		end
		else
		begin
			if (wrAccept && paddr == OFF_CTRL)
			begin
				macEnable <= pwdata[CTRL_MAC_EN];
				txEnable <= pwdata[CTRL_TX_EN];
			end
			if (wrAccept && paddr == OFF_CTRL && pwdata[CTRL_PAUSE])
				pauseReq <= 1'b1;
			else if (txStart && pauseReq)
				pauseReq <= 1'b0;
			if (wrAccept && paddr == OFF_PAUSE)
				pauseTime <= pwdata[15:0];
			if (wrAccept && paddr == OFF_VIEW)
				viewIndex <= pwdata[VIEW_IDX_LSB +: 3];
		end
	end

	// Station address: each half locks on its first accepted write made while the MAC is disabled
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			stationAddr <= ADDR_RESET;
			lockLo <= 1'b0;
			lockHi <= 1'b0;
		end
		else if (wrAccept && !macEnable)
		begin
			if (paddr == OFF_ADDR_LO && !lockLo)
			begin
				stationAddr[31:0] <= pwdata;
				lockLo <= 1'b1;
			end
			if (paddr == OFF_ADDR_HI && !lockHi)
			begin
				stationAddr[47:32] <= pwdata[15:0];
				lockHi <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter view
	// ----------------------------------------------------------------
	always_comb
	begin
		case (viewIndex)
			IDX_TXBYTES: viewValue = txBytes;
			IDX_BACKOFF_SLOT_COUNT: viewValue = {1'b0, backoff_slot_count};
			IDX_RETRY: viewValue = {7'h0, retryCount};
			IDX_RANDOM: viewValue = {1'b0, lfsr};
			default: viewValue = 11'h0;
		endcase
	end

	// Free-running while enabled so collisions seldom pick the same draw
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			lfsr <= LFSR_SEED;
		else if (txEnable)
			lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	assign txActive = txState inside {TX_PRE, TX_DATA, TX_PAD, TX_CRC, TX_END};
	assign txStart = txEdge && txState == TX_IDLE && macEnable && txEnable && (pauseReq || txValid);
	assign pauseHdr = {PAUSE_DA, stationAddr, PAUSE_TYPE, PAUSE_OP, pauseTime};
	assign expo = retryCount >= BACKOFF_CAP - 4'h1 ? BACKOFF_CAP : retryCount + 4'h1;
	assign backoffMask = 10'h3ff >> (BACKOFF_CAP - expo);

	always_comb
	begin
		logic [143:0] shifted;
		shifted = pauseHdr << {txCnt[4:0], 3'h0};
		case (txState)
			TX_PRE: txByteSel = txCnt == SFD_INDEX ? SFD_BYTE : PRE_BYTE;
			TX_DATA: txByteSel = pauseMode ? shifted[143:136] : txData;
			TX_PAD: txByteSel = 8'h00;
			TX_CRC: txByteSel = ~crc[7:0];
			default: txByteSel = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		txAck <= 1'b0;
		txRewind <= 1'b0;
		if (rst)
		begin
			txState <= TX_IDLE;
			miiTx <= '0;
			nibHi <= 1'b0;
			hiNib <= 4'h0;
			pauseMode <= 1'b0;
			txCnt <= 11'h0;
			txBytes <= 11'h0;
			crc <= CRC_INIT;
			retryCount <= 4'h0;
			backoff_slot_count <= 10'h0;
			slotNib <= 8'h0;
			backoffTarget <= 10'h0;
		end
		else if (txEdge)
		begin
			if (txActive && colS)
			begin
				miiTx <= '0;
				txRewind <= 1'b1;
				if (retryCount == RETRY_LIMIT)
					txState <= TX_IDLE;
				else
				begin
					retryCount <= retryCount + 4'h1;
					backoffTarget <= lfsr & backoffMask;
					txState <= TX_BACKOFF;
				end
			end
			else if (txState == TX_IDLE || txState == TX_BACKOFF)
			begin
				miiTx <= '0;
				nibHi <= 1'b0;
				txCnt <= 11'h0;
				crc <= CRC_INIT;
				if (txState == TX_BACKOFF)
				begin
					if (backoff_slot_count == backoffTarget)
					begin
						backoff_slot_count <= 10'h0;
						slotNib <= 8'h0;
						txBytes <= 11'h0;
						txState <= TX_PRE;
					end
					else if (slotNib == SLOT_NIBBLES - 8'h1)
					begin
						slotNib <= 8'h0;
						backoff_slot_count <= backoff_slot_count + 10'h1;
					end
					else
						slotNib <= slotNib + 8'h1;
				end
				else if (txStart)
				begin
					pauseMode <= pauseReq;
					retryCount <= 4'h0;
					txBytes <= 11'h0;
					txState <= TX_PRE;
				end
			end
			else if (nibHi)
			begin
				miiTx.d <= hiNib;
				nibHi <= 1'b0;
			end
			else if (txState == TX_END)
			begin
				miiTx <= '0;
				txState <= TX_IDLE;
			end
			else
			begin
				miiTx <= '{en: 1'b1, d: txByteSel[3:0]};
				hiNib <= txByteSel[7:4];
				nibHi <= 1'b1;
				txCnt <= txCnt + 11'h1;
				case (txState)
					TX_PRE:
						if (txCnt == SFD_INDEX)
						begin
							txCnt <= 11'h0;
							txState <= TX_DATA;
						end
					TX_DATA:
					begin
						crc <= crcByte(crc, txByteSel);
						if (!pauseMode)
						begin
							txAck <= 1'b1;
							txBytes <= txBytes + 11'h1;
						end
						if (pauseMode ? txCnt == PAUSE_LAST : (txLast || !txValid))
						begin
							if (txCnt + 11'h1 < MIN_NOCRC)
								txState <= TX_PAD;
							else
							begin
								txCnt <= 11'h0;
								txState <= TX_CRC;
							end
						end
					end
					TX_PAD:
					begin
						crc <= crcByte(crc, txByteSel);
						if (txCnt == MIN_NOCRC - 11'h1)
						begin
							txCnt <= 11'h0;
							txState <= TX_CRC;
						end
					end
					TX_CRC:
					begin
						crc <= {8'h00, crc[31:8]};
						if (txCnt == CRC_LAST)
							txState <= TX_END;
					end
					default: txState <= TX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Receiver: preamble, address and type/length checks
	// ----------------------------------------------------------------
	assign rxByte = {rxDS, rxLo};
	assign addrShift = stationAddr << {rxCnt[2:0], 3'h0};
	assign dataLen = rxCnt - HDR_BYTES;
	assign expectLen = typeLen[10:0] < MIN_DATA ? MIN_DATA : typeLen[10:0];

	always_comb
	begin
		next_rxStat.unicastHit = !mcast && addrHit;
		next_rxStat.multicast = mcast;
		next_rxStat.broadcast = bcast;
		next_rxStat.lengthErr = typeLen <= LEN_MAX && dataLen != expectLen;
		next_rxStat.typeInvalid = typeLen > LEN_MAX && typeLen < TYPE_MIN;
		next_rxStat.fragment = rxCnt < MIN_FRAME;
		next_rxStat.tooLong = rxCnt > MAX_FRAME;
		next_rxStat.length = rxCnt;
	end

	always_ff @(posedge sys_clk)
	begin
		rxDone <= 1'b0;
		if (rst)
		begin
			rxState <= RX_IDLE;
			rxNibHi <= 1'b0;
			rxLo <= 4'h0;
			rxCnt <= 11'h0;
			addrHit <= 1'b0;
			mcast <= 1'b0;
			bcast <= 1'b0;
			typeLen <= 16'h0;
			rxStatus <= '0;
		end
		else if (rxEdge)
		begin
			if (!rxDvS)
			begin
				if (rxState == RX_DATA)
				begin
					rxDone <= 1'b1;
					rxStatus <= next_rxStat;
				end
				rxState <= RX_IDLE;
				rxNibHi <= 1'b0;
			end
			else if (rxState == RX_IDLE)
			begin
				rxLo <= rxDS;
				rxNibHi <= 1'b1;
				rxState <= macEnable ? RX_PRE : RX_DROP;
			end
			else if (rxState != RX_DROP && !rxNibHi)
			begin
				rxLo <= rxDS;
				rxNibHi <= 1'b1;
			end
			else if (rxState != RX_DROP)
			begin
				rxNibHi <= 1'b0;
				if (rxState == RX_PRE)
				begin
					if (rxByte == SFD_BYTE)
					begin
						rxState <= RX_DATA;
						rxCnt <= 11'h0;
						addrHit <= 1'b1;
						bcast <= 1'b1;
						typeLen <= 16'h0;
					end
					else if (rxByte != PRE_BYTE)
						rxState <= RX_DROP;
				end
				else
				begin
					if (rxCnt != 11'h7ff)
						rxCnt <= rxCnt + 11'h1;
					if (rxCnt < DA_BYTES)
					begin
						if (rxByte != addrShift[47:40])
							addrHit <= 1'b0;
						if (rxByte != BCAST_ADDR[7:0])
							bcast <= 1'b0;
					end
					if (rxCnt == 11'h0)
						mcast <= rxByte[0];
					if (rxCnt == TL_HI_INDEX)
						typeLen[15:8] <= rxByte;
					if (rxCnt == TL_LO_INDEX)
						typeLen[7:0] <= rxByte;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	addr_lock_a: assert property (lockLo && lockHi |=> $stable(stationAddr))
		else $error("station address changed after lock");
	view_zero_a: assert property (viewIndex inside {3'h0, 3'h1, 3'h2, 3'h7} |-> viewValue == 11'h0)
		else $error("unused counter index reads nonzero");
	retry_upper_a: assert property (viewIndex == IDX_RETRY |-> viewValue[10:4] == 7'h0)
		else $error("retry view upper bits nonzero");
	view_write_a: assert property (wrAccept && paddr == OFF_VIEW
		|=> viewIndex == $past(pwdata[15:13]))
		else $error("counter index not written");
	pre_start_a: assert property ($rose(miiTx.en) |-> miiTx.d == PRE_BYTE[3:0])
		else $error("frame does not open with preamble nibble");
	pad_zero_a: assert property (txState == TX_PAD && txEdge && !nibHi && !colS
		|=> miiTx.d == 4'h0 ##1 (nibHi && miiTx.d == 4'h0) [*2])
		else $error("pad nibble not zero");
	idle_quiet_a: assert property (txState == TX_IDLE |-> !miiTx.en)
		else $error("transmit enable high while idle");
	slot_clear_a: assert property (txState != TX_BACKOFF |-> backoff_slot_count == 10'h0)
		else $error("slot count not cleared outside backoff");
	random_run_a: assert property (txEnable |=> lfsr != $past(lfsr))
		else $error("random value stalled");
	bcast_mc_a: assert property (rxDone && rxStatus.broadcast |-> rxStatus.multicast)
		else $error("broadcast not flagged as multicast");
	len_type_a: assert property (rxDone && rxStatus.typeInvalid |-> !rxStatus.lengthErr)
		else $error("invalid type was length-checked");

	pause_sent_c: cover property (txState == TX_DATA && pauseMode ##[1:1000] txState == TX_CRC);
	backoff_c: cover property (txState == TX_BACKOFF ##[1:1000] txState == TX_PRE);
	rx_lenerr_c: cover property (rxDone && rxStatus.lengthErr);
	rx_drop_c: cover property (rxState == RX_DROP);
endmodule

// file: efc_pkg.sv
// Shared constants and carrier types for the Ethernet frame and counter block
// Operation
// - Stored 48-bit station address is matched exactly against received unicast destinations.
// - Pause frames carry the stored station address as their source address.
// - Station address takes one write after reset, never while the MAC is enabled.
// - Counter view index is always writable; its value field is read-only.
// - Index 0-2 reads zero; 3 tx bytes, 4 slots, 5 retries, 6 random.
// - Tx byte count covers fetched frame bytes only, not pad, checksum or pause.
// - Backoff slot count counts 512-bit-time slots, clears at backoff end, bit 10 zero.
// - Retry count is four bits; value bits ten down to four read zero.
// - A 10-bit random value feeds backoff and runs while transmitter is enabled.
// - Frame is preamble, delimiter, destination, source, type/length, data, checksum.
// - Frame is 64 to 1518 bytes without preamble; bytes cross as two nibbles.
// - Preamble is alternating ones and zeros, then delimiter 10101011.
// - Receiver accepts missing preamble but drops frames with a broken preamble.
// - Address bytes go most significant byte first, each byte LSB first.
// - First byte bit zero clear means unicast, set multicast; all ones is broadcast.
// - Type/length sent high byte first; up to 0x05DC it is a checked length.
// - Values 0x0600 and above are protocol types with no length check.
// - Values 1501 to 1535 mark invalid frames, neither rejected nor length-checked.
// - Short data is padded with zero bytes before the checksum.
// - Transmitter appends 32-bit CRC, highest coefficient first.
// - Frame ends when transmit enable or receive data valid deasserts.
package efc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_ADDR_LO = 12'h008;
	localparam logic [11:0] OFF_ADDR_HI = 12'h00c;
	localparam logic [11:0] OFF_VIEW = 12'h010;
	localparam logic [11:0] OFF_PAUSE = 12'h014;
	localparam int CTRL_MAC_EN = 0;
	localparam int CTRL_TX_EN = 1;
	localparam int CTRL_PAUSE = 2;
	localparam int VIEW_IDX_LSB = 13;
	localparam logic [2:0] IDX_TXBYTES = 3'h3;
	localparam logic [2:0] IDX_BACKOFF_SLOT_COUNT = 3'h4;
	localparam logic [2:0] IDX_RETRY = 3'h5;
	localparam logic [2:0] IDX_RANDOM = 3'h6;
	localparam logic [47:0] ADDR_RESET = 48'h0;
	localparam logic [15:0] PAUSE_TIME_RESET = 16'h0;
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [7:0] PRE_BYTE = 8'h55;
	localparam logic [7:0] SFD_BYTE = 8'hd5;
	localparam logic [10:0] SFD_INDEX = 11'h007;
	localparam logic [10:0] MIN_NOCRC = 11'h03c;
	localparam logic [10:0] CRC_LAST = 11'h003;
	localparam logic [10:0] HDR_BYTES = 11'h012;
	localparam logic [10:0] MIN_FRAME = 11'h040;
	localparam logic [10:0] MAX_FRAME = 11'h5ee;
	localparam logic [10:0] MIN_DATA = 11'h02e;
	localparam logic [10:0] TL_HI_INDEX = 11'h00c;
	localparam logic [10:0] TL_LO_INDEX = 11'h00d;
	localparam logic [10:0] DA_BYTES = 11'h006;
	localparam logic [15:0] LEN_MAX = 16'h05dc;
	localparam logic [15:0] TYPE_MIN = 16'h0600;
	localparam logic [47:0] BCAST_ADDR = 48'hffffffffffff;
	localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
	localparam logic [15:0] PAUSE_TYPE = 16'h8808;
	localparam logic [15:0] PAUSE_OP = 16'h0001;
	localparam logic [10:0] PAUSE_LAST = 11'h011;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	// ----------------------------------------------------------------
	// Backoff timing, counted in link nibbles
	// ----------------------------------------------------------------
	localparam int SLOT_BITS = 512;
	localparam logic [7:0] SLOT_NIBBLES = 8'(SLOT_BITS / 4);
	localparam logic [3:0] RETRY_LIMIT = 4'hf;
	localparam logic [3:0] BACKOFF_CAP = 4'ha;
	localparam logic [9:0] LFSR_SEED = 10'h001;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic [3:0] d;
	} efc_miitx_t;
	typedef struct packed {
		logic unicastHit;
		logic multicast;
		logic broadcast;
		logic lengthErr;
		logic typeInvalid;
		logic fragment;
		logic tooLong;
		logic [10:0] length;
	} efc_rxstat_t;
endpackage

// file: efc_phy_model.sv
// Link partner model: link clocks, receive frame source and transmit capture
`timescale 1ns/1ps
module efc_phy_model (
	// MII toward the MAC
	output logic miiTxClk,
	output logic miiRxClk,
	output logic miiRxDv,
	output logic [3:0] miiRxD,
	output logic miiCol,
	input wire efc_pkg::efc_miitx_t miiTx
);
	import efc_pkg::*;
	logic [7:0] txBytes[$];
	logic txDone;
	logic busy;
	logic half;
	logic [3:0] lowNib;
	logic colArm;
	// ----------------------------------------------------------------
	// Clocks and frames
	// ----------------------------------------------------------------
	// The PHY sources both clocks, and the MAC needs them between frames
	initial
	begin
		miiTxClk = 1'b0;
		miiRxClk = 1'b0;
		miiRxDv = 1'b0;
		miiRxD = 4'h0;
		miiCol = 1'b0;
		txDone = 1'b0;
		busy = 1'b0;
		half = 1'b0;
		lowNib = 4'h0;
		colArm = 1'b0;
		fork
			forever #40 miiTxClk = ~miiTxClk;
			#17 forever #40 miiRxClk = ~miiRxClk;
		join
	end
	task automatic send(input logic [7:0] b[$], input int npre, input logic bad);
		logic [7:0] f[$];
		f = {};
		for (int i = 0; i < npre; i++) f.push_back((bad && i == 2) ? 8'h54 : PRE_BYTE);
		f.push_back(SFD_BYTE);
		f = {f, b};
		foreach (f[i])
		begin
			@(negedge miiRxClk);
			miiRxDv <= 1'b1;
			miiRxD <= f[i][3:0];
			@(negedge miiRxClk);
			miiRxD <= f[i][7:4];
		end
		@(negedge miiRxClk);
		miiRxDv <= 1'b0;
		// Released data must not look like the last nibble
		miiRxD <= ~f[f.size() - 1][7:4];
	endtask
	// One-shot collision on the first transmit clock that sees enable
	always @(posedge miiTxClk)
	begin
		if (colArm && miiTx.en)
		begin
			miiCol <= 1'b1;
			colArm = 1'b0;
		end
		else
			miiCol <= 1'b0;
	end
	always @(posedge miiTxClk)
	begin
		if (miiTx.en)
		begin
			if (!busy)
			begin
				txBytes.delete();
				busy = 1'b1;
				half = 1'b0;
			end
			if (half)
				txBytes.push_back({miiTx.d, lowNib});
			else
				lowNib = miiTx.d;
			half = !half;
		end
		else if (busy)
		begin
			busy = 1'b0;
			txDone = 1'b1;
		end
	end
endmodule

// file: efc_testbench.sv
// Self-checking bench for the frame and counter block
`timescale 1ns/1ps
module testbench;
	import efc_pkg::*;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r1;
	logic miiTxClk, miiRxClk, miiRxDv, miiCol, txValid, txLast, txAck, txRewind, rxDone;
	logic [3:0] miiRxD;
	logic [7:0] txData;
	efc_miitx_t miiTx;
	efc_rxstat_t rxStatus;
	int errCount, comparisons;
	localparam logic [47:0] STA = 48'h02a1b2c3d4e5;
	efc_mac dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .miiTxClk(miiTxClk), .miiRxClk(miiRxClk), .miiRxDv(miiRxDv),
		.miiRxD(miiRxD), .miiCol(miiCol), .miiTx(miiTx), .txData(txData), .txValid(txValid),
		.txLast(txLast), .txAck(txAck), .txRewind(txRewind), .rxDone(rxDone),
		.rxStatus(rxStatus));
	efc_phy_model phy_u (.miiTxClk(miiTxClk), .miiRxClk(miiRxClk), .miiRxDv(miiRxDv),
		.miiRxD(miiRxD), .miiCol(miiCol), .miiTx(miiTx));
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			errCount++;
		end
	endtask
	task end_of_test;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, errCount);
		if (errCount == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic hang(input string n);
		$display("wrong value %s expected handshake seen none", n);
		errCount++;
		end_of_test();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			hang("pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdk(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	function automatic logic [31:0] crc(input logic [7:0] b[$]);
		logic [31:0] c;
		c = CRC_INIT;
		foreach (b[i])
			for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? CRC_POLY : 32'h0);
		return ~c;
	endfunction
	task automatic wait_tx;
		int n;
		n = 0;
		while (phy_u.txDone !== 1'b1 && n < 6000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 6000)
			hang("tx frame end");
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		rdk("ctrl", OFF_CTRL, 32'h0);
		rdk("view", OFF_VIEW, 32'h0);
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		apb(1'b1, OFF_CTRL, 32'h1);
		apb(1'b1, OFF_ADDR_HI, 32'h1234);
		rdk("addr hi enabled", OFF_ADDR_HI, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_ADDR_HI, {16'h0, STA[47:32]});
		apb(1'b1, OFF_ADDR_LO, STA[31:0]);
		apb(1'b1, OFF_ADDR_HI, 32'hffff);
		apb(1'b1, OFF_ADDR_LO, 32'hffffffff);
		rdk("addr hi", OFF_ADDR_HI, {16'h0, STA[47:32]});
		rdk("addr lo", OFF_ADDR_LO, STA[31:0]);
		$display("test registers done");
	endtask
	task automatic t_view;
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, OFF_VIEW, {16'h0, 3'(i), 13'h1fff});
			apb(1'b0, OFF_VIEW, 32'h0);
			chk("view index", 32'(i), {29'h0, rd[15:13]});
			chk("view value", 32'h0, rd & ((i == 6) ? 32'h400 : 32'h7ff));
		end
		apb(1'b1, OFF_VIEW, {16'h0, IDX_RANDOM, 13'h0});
		apb(1'b1, OFF_CTRL, 32'h3);
		apb(1'b0, OFF_VIEW, 32'h0);
		r1 = rd;
		repeat (100) @(posedge sys_clk);
		apb(1'b0, OFF_VIEW, 32'h0);
		chk("random moves", 32'h1, {31'h0, r1[9:0] !== rd[9:0]});
		$display("test counter view done");
	endtask
	task automatic t_tx;
		logic [7:0] q[$], e[$], body[$];
		logic [31:0] c;
		int i, n, rw;
		q = {};
		rw = 0;
		for (int k = 0; k < 6; k++) q.push_back(8'h0a + 8'(k));
		for (int k = 0; k < 6; k++) q.push_back(STA[47 - 8 * k -: 8]);
		q = {q, 8'h00, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
		phy_u.txDone = 1'b0;
		phy_u.colArm = 1'b1;
		@(posedge sys_clk);
		txData <= q[0];
		txValid <= 1'b1;
		txLast <= 1'b0;
		for (i = 0; i < q.size(); i++)
		begin
			n = 0;
			do
			begin
				@(posedge sys_clk);
				n++;
				if (txRewind === 1'b1)
					rw++;
			end
			while (txAck !== 1'b1 && n < 4000);
			if (n >= 4000)
				hang("txAck");
			txData <= (i + 1 < q.size()) ? q[i + 1] : 8'h0;
			txLast <= (i + 2 == q.size());
			txValid <= (i + 1 < q.size());
		end
		// The collided attempt already raised the end flag
		phy_u.txDone = 1'b0;
		wait_tx();
		body = q;
		while (body.size() < 60) body.push_back(8'h00);
		c = crc(body);
		e = {PRE_BYTE, PRE_BYTE, PRE_BYTE, PRE_BYTE, PRE_BYTE, PRE_BYTE, PRE_BYTE, SFD_BYTE};
		e = {e, body, c[7:0], c[15:8], c[23:16], c[31:24]};
		chk("tx size", 32'd72, 32'(phy_u.txBytes.size()));
		foreach (e[k]) chk("tx byte", {24'h0, e[k]}, {24'h0, phy_u.txBytes[k]});
		chk("tx rewind", 32'd1, 32'(rw));
		apb(1'b1, OFF_VIEW, {16'h0, IDX_RETRY, 13'h0});
		apb(1'b0, OFF_VIEW, 32'h0);
		chk("retry count", 32'd1, {21'h0, rd[10:0]});
		apb(1'b1, OFF_VIEW, {16'h0, IDX_TXBYTES, 13'h0});
		apb(1'b0, OFF_VIEW, 32'h0);
		chk("tx byte count", 32'(q.size()), {21'h0, rd[10:0]});
		phy_u.txDone = 1'b0;
		apb(1'b1, OFF_PAUSE, 32'h5);
		apb(1'b1, OFF_CTRL, 32'h7);
		wait_tx();
		for (int k = 0; k < 6; k++) chk("pause sa", {24'h0, STA[47 - 8 * k -: 8]}, {24'h0, phy_u.txBytes[14 + k]});
		$display("test transmit done");
	endtask
	task automatic rx_case(input logic [47:0] da, input logic [15:0] tl, input int npre,
		input logic bad, input logic expDone, input logic [6:0] expBits);
		logic [7:0] f[$];
		int n;
		f = {};
		for (int k = 0; k < 6; k++) f.push_back(da[47 - 8 * k -: 8]);
		for (int k = 0; k < 6; k++) f.push_back(8'h10 + 8'(k));
		f = {f, tl[15:8], tl[7:0]};
		for (int k = 0; k < 50; k++) f.push_back(8'(k));
		phy_u.send(f, npre, bad);
		n = 0;
		while (rxDone !== 1'b1 && n < 400)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk("rx done", {31'h0, expDone}, {31'h0, n < 400});
		if (expDone)
		begin
			chk("rx flags", {25'h0, expBits}, {25'h0, rxStatus[17:11]});
			chk("rx length", 32'd64, {21'h0, rxStatus.length});
		end
	endtask
	task t_rx;
		rx_case(STA, 16'h0800, 7, 1'b0, 1'b1, 7'b1000000);
		rx_case(BCAST_ADDR, 16'h0030, 0, 1'b0, 1'b1, 7'b0111000);
		rx_case(48'h030000000000, 16'h05e0, 3, 1'b0, 1'b1, 7'b0100100);
		rx_case(STA ^ 48'h1, 16'h002e, 7, 1'b0, 1'b1, 7'b0000000);
		rx_case(STA, 16'h0800, 5, 1'b1, 1'b0, 7'b0);
		$display("test receive done");
	endtask
	task t_reset;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rdk("addr lo reset", OFF_ADDR_LO, ADDR_RESET[31:0]);
		apb(1'b1, OFF_ADDR_LO, 32'h12345678);
		rdk("addr lo rewrite", OFF_ADDR_LO, 32'h12345678);
		$display("test reset done");
	endtask
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		txData = 8'h0;
		txValid = 1'b0;
		txLast = 1'b0;
		errCount = 0;
		comparisons = 0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_view();
		t_tx();
		t_rx();
		t_reset();
		end_of_test();
	end
endmodule
